// File: hdl/mau_pkg.sv
/*
 * mau_pkg: constants and carrier types for the multiply-accumulate unit.
 * assumes: 32-bit apb register bus, one clock, synchronous reset.
 */
package mau_pkg;
	// ----------------------------------------
	// datapath widths
	// ----------------------------------------
	localparam int MAU_OP_W = 18;
	localparam int MAU_PROD_W = 2 * MAU_OP_W;
	localparam int MAU_ACC_W = 52;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] MAU_CTRL_OFS = 8'h00;
	localparam logic [7:0] MAU_CE_SEL_OFS = 8'h04;
	localparam logic [7:0] MAU_RST_SEL_OFS = 8'h08;
	localparam logic [7:0] MAU_STATUS_OFS = 8'h0C;
	localparam logic [7:0] MAU_MASK_OFS = 8'h10;
	localparam logic [7:0] MAU_RESULT_OFS = 8'h14;

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	localparam int MAU_CTRL_IN_EN = 0;
	localparam int MAU_CTRL_PIPE_EN = 1;
	localparam int MAU_CTRL_OUT_EN = 2;
	localparam int MAU_CTRL_MAC = 3;
	localparam int MAU_CTRL_W = 4;
	localparam logic [3:0] MAU_CTRL_RST = 4'h0;
	// two-bit source selectors: input [1:0], pipeline [3:2], output [5:4]
	localparam int MAU_SEL_IN_LSB = 0;
	localparam int MAU_SEL_PIPE_LSB = 2;
	localparam int MAU_SEL_OUT_LSB = 4;
	localparam int MAU_SEL_W = 6;
	localparam logic [5:0] MAU_SEL_RST = 6'h00;
	localparam int MAU_STAT_OVF = 0;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic sgn;
		logic sub;
		logic [MAU_OP_W-1:0] a;
		logic [MAU_OP_W-1:0] b;
	} mau_ops_t;

	typedef struct packed {
		logic sgn;
		logic sub;
		logic [MAU_PROD_W-1:0] p;
	} mau_prod_t;
endpackage : mau_pkg

// File: hdl/mau_top.sv
/*
 * mau_top: multiplier / multiply-accumulate datapath with optional
 * input, pipeline and output registers and an apb control slave.
 * assumes: fabric inputs synchronous to core_clk_in; operands already
 * widened to the native width by the supplying logic.
 */
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
module mau_top (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// operands and per-cycle controls
	input wire logic [mau_pkg::MAU_OP_W-1:0] operand_a_in,
	input wire logic [mau_pkg::MAU_OP_W-1:0] operand_b_in,
	input wire logic serial_a_in,
	input wire logic serial_b_in,
	input wire logic load_serial_in,
	input wire logic signed_in,
	input wire logic subtract_in,
	// enable and reset sources
	input wire logic clock_enable_source_a_in,
	input wire logic clock_enable_source_b_in,
	input wire logic clock_enable_source_c_in,
	input wire logic clock_enable_source_d_in,
	input wire logic reset_source_a_in,
	input wire logic reset_source_b_in,
	input wire logic reset_source_c_in,
	input wire logic reset_source_d_in,
	// results
	output logic [mau_pkg::MAU_ACC_W-1:0] result_out,
	output logic overflow_out,
	output logic irq_out
);
	localparam int W = mau_pkg::MAU_OP_W;
	localparam int PW = mau_pkg::MAU_PROD_W;
	localparam int AW = mau_pkg::MAU_ACC_W;

	// ----------------------------------------
	// source selection
	// ----------------------------------------
	logic [3:0] ce_src;
	logic [3:0] rst_src;
	logic [mau_pkg::MAU_CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic [mau_pkg::MAU_SEL_W-1:0] ce_sel_reg, ce_sel_next;
	logic [mau_pkg::MAU_SEL_W-1:0] rst_sel_reg, rst_sel_next;
	logic ce_in_stage, ce_pipe_stage, ce_out_stage;
	logic rst_in_stage, rst_pipe_stage, rst_out_stage;
	logic in_en, pipe_en, out_en, mac_mode;

	assign ce_src = {clock_enable_source_d_in, clock_enable_source_c_in,
		clock_enable_source_b_in, clock_enable_source_a_in};
	assign rst_src = {reset_source_d_in, reset_source_c_in, reset_source_b_in, reset_source_a_in};
	assign in_en = ctrl_reg[mau_pkg::MAU_CTRL_IN_EN];
	assign pipe_en = ctrl_reg[mau_pkg::MAU_CTRL_PIPE_EN];
	assign out_en = ctrl_reg[mau_pkg::MAU_CTRL_OUT_EN];
	assign mac_mode = ctrl_reg[mau_pkg::MAU_CTRL_MAC];
	// one of four enables and resets per stage
	assign ce_in_stage = ce_src[ce_sel_reg[mau_pkg::MAU_SEL_IN_LSB +: 2]];
	assign ce_pipe_stage = ce_src[ce_sel_reg[mau_pkg::MAU_SEL_PIPE_LSB +: 2]];
	assign ce_out_stage = ce_src[ce_sel_reg[mau_pkg::MAU_SEL_OUT_LSB +: 2]];
	assign rst_in_stage = rst_src[rst_sel_reg[mau_pkg::MAU_SEL_IN_LSB +: 2]];
	assign rst_pipe_stage = rst_src[rst_sel_reg[mau_pkg::MAU_SEL_PIPE_LSB +: 2]];
	assign rst_out_stage = rst_src[rst_sel_reg[mau_pkg::MAU_SEL_OUT_LSB +: 2]];

	// ----------------------------------------
	// input stage
	// ----------------------------------------
	mau_pkg::mau_ops_t ops_in, in_reg, in_next, ops_s1;

	assign ops_in = '{sgn: signed_in, sub: subtract_in, a: operand_a_in, b: operand_b_in};

	always_comb begin
		in_next = in_reg;
		if (rst_in_stage) begin
			in_next = '0;
		end else if (ce_in_stage) begin
			in_next = ops_in;
			if (load_serial_in) begin
				// shift one bit per cycle, msb first
				in_next.a = {in_reg.a[W-2:0], serial_a_in};
				in_next.b = {in_reg.b[W-2:0], serial_b_in};
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			in_reg <= '0;
		end else begin
			in_reg <= in_next;
		end
	end

	assign ops_s1 = in_en ? in_reg : ops_in;

	// ----------------------------------------
	// multiplier and pipeline stage
	// ----------------------------------------
	logic signed [W:0] a_ext, b_ext;
	logic signed [2*W+1:0] prod_wide;
	mau_pkg::mau_prod_t prod_s1, pipe_reg, pipe_next, pp;

	// one extra bit makes a single signed multiply serve both views
	assign a_ext = {ops_s1.sgn & ops_s1.a[W-1], ops_s1.a};
	assign b_ext = {ops_s1.sgn & ops_s1.b[W-1], ops_s1.b};
	assign prod_wide = a_ext * b_ext;
	assign prod_s1 = '{sgn: ops_s1.sgn, sub: ops_s1.sub, p: prod_wide[PW-1:0]};

	always_comb begin
		pipe_next = pipe_reg;
		if (rst_pipe_stage) begin
			pipe_next = '0;
		end else if (ce_pipe_stage) begin
			pipe_next = prod_s1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			pipe_reg <= '0;
		end else begin
			pipe_reg <= pipe_next;
		end
	end

	assign pp = pipe_en ? pipe_reg : prod_s1;

	// ----------------------------------------
	// accumulator / output stage
	// ----------------------------------------
	logic [AW-1:0] prod_acc, acc_sum, out_reg, out_next;
	logic out_upd, wrap, ovf_reg, ovf_next;

	assign prod_acc = {{(AW-PW){pp.sgn & pp.p[PW-1]}}, pp.p};
	assign out_upd = ce_out_stage & ~rst_out_stage;
	// modulo arithmetic, no saturation
	assign acc_sum = pp.sub ? out_reg - prod_acc : out_reg + prod_acc;

	always_comb begin
		wrap = 1'b0;
		if (pp.sgn) begin
			// like signs into add, unlike into subtract, then sign flips
			wrap = ((out_reg[AW-1] ^ prod_acc[AW-1]) == pp.sub) && (acc_sum[AW-1] != out_reg[AW-1]);
		end else if (pp.sub) begin
			wrap = acc_sum > out_reg;
		end else begin
			wrap = acc_sum < out_reg;
		end
	end

	always_comb begin
		out_next = out_reg;
		ovf_next = 1'b0;
		if (rst_out_stage) begin
			out_next = '0;
		end else if (ce_out_stage) begin
			out_next = mac_mode ? acc_sum : prod_acc;
			ovf_next = mac_mode & wrap;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			out_reg <= '0;
			ovf_reg <= 1'b0;
		end else begin
			out_reg <= out_next;
			ovf_reg <= ovf_next;
		end
	end

	// accumulator is always registered; bypass applies to the product path
	assign result_out = (out_en | mac_mode) ? out_reg : prod_acc;
	assign overflow_out = ovf_reg;

	// ----------------------------------------
	// apb slave and interrupt
	// ----------------------------------------
	logic pready_reg, pready_next, pslverr_reg, pslverr_next;
	logic [31:0] prdata_reg, prdata_next;
	logic stat_reg, stat_next, mask_reg, mask_next, irq_reg, irq_next;
	logic acc_phase, wr_go, rd_go, hit;

	assign acc_phase = psel_in & penable_in;
	assign wr_go = acc_phase & pready_reg & pwrite_in;
	assign rd_go = acc_phase & pready_reg & ~pwrite_in;

	always_comb begin
		hit = 1'b1;
		unique case (paddr_in)
			mau_pkg::MAU_CTRL_OFS, mau_pkg::MAU_CE_SEL_OFS, mau_pkg::MAU_RST_SEL_OFS,
			mau_pkg::MAU_STATUS_OFS, mau_pkg::MAU_MASK_OFS, mau_pkg::MAU_RESULT_OFS: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	always_comb begin
		ctrl_next = ctrl_reg;
		ce_sel_next = ce_sel_reg;
		rst_sel_next = rst_sel_reg;
		mask_next = mask_reg;
		stat_next = stat_reg;
		prdata_next = prdata_reg;
		pready_next = acc_phase & ~pready_reg;
		pslverr_next = acc_phase & ~pready_reg & ~hit;
		if (acc_phase & ~pready_reg) begin
			prdata_next = 32'h0000_0000;
			unique case (paddr_in)
				mau_pkg::MAU_CTRL_OFS: prdata_next[mau_pkg::MAU_CTRL_W-1:0] = ctrl_reg;
				mau_pkg::MAU_CE_SEL_OFS: prdata_next[mau_pkg::MAU_SEL_W-1:0] = ce_sel_reg;
				mau_pkg::MAU_RST_SEL_OFS: prdata_next[mau_pkg::MAU_SEL_W-1:0] = rst_sel_reg;
				mau_pkg::MAU_STATUS_OFS: prdata_next[mau_pkg::MAU_STAT_OVF] = stat_reg;
				mau_pkg::MAU_MASK_OFS: prdata_next[mau_pkg::MAU_STAT_OVF] = mask_reg;
				mau_pkg::MAU_RESULT_OFS: prdata_next = out_reg[31:0];
				default: prdata_next = 32'h0000_0000;
			endcase
		end
		if (wr_go) begin
			unique case (paddr_in)
				mau_pkg::MAU_CTRL_OFS: ctrl_next = pwdata_in[mau_pkg::MAU_CTRL_W-1:0];
				mau_pkg::MAU_CE_SEL_OFS: ce_sel_next = pwdata_in[mau_pkg::MAU_SEL_W-1:0];
				mau_pkg::MAU_RST_SEL_OFS: rst_sel_next = pwdata_in[mau_pkg::MAU_SEL_W-1:0];
				mau_pkg::MAU_MASK_OFS: mask_next = pwdata_in[mau_pkg::MAU_STAT_OVF];
				default: ;
			endcase
		end
		// read clears, a new overflow wins
		if (rd_go && paddr_in == mau_pkg::MAU_STATUS_OFS) begin
			stat_next = 1'b0;
		end
		if (ovf_next) begin
			stat_next = 1'b1;
		end
		irq_next = stat_next & mask_next;
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			ctrl_reg <= mau_pkg::MAU_CTRL_RST;
			ce_sel_reg <= mau_pkg::MAU_SEL_RST;
			rst_sel_reg <= mau_pkg::MAU_SEL_RST;
			mask_reg <= 1'b0;
			stat_reg <= 1'b0;
			irq_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			ce_sel_reg <= ce_sel_next;
			rst_sel_reg <= rst_sel_next;
			mask_reg <= mask_next;
			stat_reg <= stat_next;
			irq_reg <= irq_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata_out = prdata_reg;
	assign pready_out = pready_reg;
	assign pslverr_out = pslverr_reg;
	assign irq_out = irq_reg;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);

	logic [AW-1:0] acc_sum_d;
	logic upd_mac_add, upd_mac_sub, upd_plain, uns_add, sgn_add;
	assign upd_mac_add = out_upd & mac_mode & ~pp.sub;
	assign upd_mac_sub = out_upd & mac_mode & pp.sub;
	assign upd_plain = out_upd & ~mac_mode & out_en;
	assign uns_add = ~pp.sgn & ~pp.sub & mac_mode;
	assign sgn_add = pp.sgn & ~pp.sub & mac_mode;
	assign acc_sum_d = acc_sum;

	sequence s_mac_step;
		out_upd && mac_mode;
	endsequence

	a_ovf_cause_pulse: assert property (ovf_reg |-> $past(out_upd) && $past(mac_mode) && $past(wrap))
		else $error("overflow pulse without a wrapping update");
	a_ovf_with_result: assert property (s_mac_step ##0 wrap |=> ovf_reg && out_reg == $past(acc_sum_d))
		else $error("overflow not aligned with wrapped result");
	a_ovf_no_hold: assert property (!(out_upd && mac_mode && wrap) |=> !ovf_reg)
		else $error("overflow held without a new wrap");
	a_uns_wrap_smaller: assert property (out_upd && uns_add && wrap |=> out_reg < $past(out_reg))
		else $error("unsigned overflow without smaller result");
	a_sgn_wrap_flip: assert property (out_upd && sgn_add && wrap |=> out_reg[AW-1] != $past(prod_acc[AW-1]))
		else $error("signed overflow without sign change");
	a_acc_add_wrap: assert property (upd_mac_add |=> out_reg == $past(out_reg) + $past(prod_acc))
		else $error("accumulator add mismatch");
	a_acc_sub_step: assert property (upd_mac_sub |=> out_reg == $past(out_reg) - $past(prod_acc))
		else $error("accumulator subtract mismatch");
	a_product_only_element_only_out: assert property (upd_plain |=> result_out == $past(prod_acc))
		else $error("multiplier output is not the product");
	a_serial_shift_in: assert property (ce_in_stage && !rst_in_stage && load_serial_in |=>
		in_reg.a == {$past(in_reg.a[W-2:0]), $past(serial_a_in)})
		else $error("serial load did not shift");
	a_stage_hold_ce: assert property (!ce_pipe_stage && !rst_pipe_stage |=> $stable(pipe_reg))
		else $error("pipeline changed without its enable");
	a_stage_src_reset: assert property (rst_in_stage |=> in_reg == '0)
		else $error("input stage ignored its reset source");
	a_signed_product: assert property (ops_s1.sgn |->
		$signed(prod_s1.p) == $signed(ops_s1.a) * $signed(ops_s1.b))
		else $error("signed product wrong");
	// all stages off: result follows the raw operands in the same cycle
	a_bypass_input: assert property (!in_en && !pipe_en && !out_en && !mac_mode && !signed_in |->
		result_out == operand_a_in * operand_b_in)
		else $error("disabled stages not transparent");
endmodule : mau_top

// File: bench/mau_fabric_model.sv
/*
 * mau_fabric_model: fabric logic in front of the unit; widens narrow
 * operands to the native width and counts overflow pulses.
 * assumes: bench drives the narrow inputs on core_clk_in.
 */
`timescale 1ns/1ps
module mau_fabric_model (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// narrow operands and wrap pulse
	input wire logic [8:0] narrow_a_in,
	input wire logic [8:0] narrow_b_in,
	input wire logic signed_in,
	input wire logic overflow_in,
	// widened operands and overflow pulse count
	output logic [mau_pkg::MAU_OP_W-1:0] operand_a_out,
	output logic [mau_pkg::MAU_OP_W-1:0] operand_b_out,
	output logic [7:0] wrap_count_out
);
	localparam int PAD = mau_pkg::MAU_OP_W - 9;
	logic [7:0] wrap_count_next;

	// zero fill when unsigned, sign copy when signed
	assign operand_a_out = {{PAD{signed_in & narrow_a_in[8]}}, narrow_a_in};
	assign operand_b_out = {{PAD{signed_in & narrow_b_in[8]}}, narrow_b_in};

	always_comb begin
		wrap_count_next = wrap_count_out + {7'h00, overflow_in};
	end

	always_ff @(posedge core_clk_in) begin
		wrap_count_out <= reset_in ? 8'h00 : wrap_count_next;
	end
endmodule : mau_fabric_model

// File: bench/tb.sv
/*
 * tb: apb register tests, stage latency, source selection, serial load
 * and accumulator wrap of mau_top.
 * assumes: mau_pkg and the fabric model are compiled first.
 */
`timescale 1ns/1ps
module tb;
	logic core_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [7:0] paddr = 8'h00, wraps;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [8:0] na = 9'h000, nb = 9'h000;
	logic sgn = 1'b0, sub = 1'b0, ser_a = 1'b0, ser_b = 1'b0, load_ser = 1'b0, e, ovf, irq;
	logic [3:0] ce = 4'hF, rst = 4'h0;
	logic [17:0] op_a, op_b;
	logic [17:0] sa = 18'h20003, sb = 18'h00005;
	logic [51:0] result;
	logic [18:0] tab [6] = '{{1'b0, 9'h005, 9'h007}, {1'b1, 9'h1FA, 9'h005}, {1'b1, 9'h1FA, 9'h1FA},
		{1'b0, 9'h1FA, 9'h1FA}, {1'b1, 9'h100, 9'h0FF}, {1'b0, 9'h003, 9'h00B}};
	logic [19:0] mt [7] = '{{2'h2, 9'h001, 9'h001}, {2'h1, 9'h001, 9'h001}, {2'h3, 9'h001, 9'h001},
		{2'h0, 9'h001, 9'h001}, {2'h0, 9'h003, 9'h005}, {2'h1, 9'h1FE, 9'h003}, {2'h0, 9'h1FE, 9'h002}};
	logic [52:0] mx [7] = '{{1'b1, 52'hFFFFFFFFFFFFF}, 53'h0, {1'b0, 52'hFFFFFFFFFFFFF}, {1'b1, 52'h0},
		53'h0F, 53'h09, 53'h405};
	int n_errors = 0;
	int samples_checked = 0;
	int lat;

	always #12.5 core_clk_in = ~core_clk_in;

	mau_top mau_top_inst (.core_clk_in(core_clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .operand_a_in(op_a), .operand_b_in(op_b), .serial_a_in(ser_a), .serial_b_in(ser_b),
		.load_serial_in(load_ser), .signed_in(sgn), .subtract_in(sub), .clock_enable_source_a_in(ce[0]),
		.clock_enable_source_b_in(ce[1]), .clock_enable_source_c_in(ce[2]), .clock_enable_source_d_in(ce[3]),
		.reset_source_a_in(rst[0]), .reset_source_b_in(rst[1]), .reset_source_c_in(rst[2]),
		.reset_source_d_in(rst[3]), .result_out(result), .overflow_out(ovf), .irq_out(irq));
	mau_fabric_model mau_fabric_model_inst (.core_clk_in(core_clk_in), .reset_in(reset_in), .narrow_a_in(na),
		.narrow_b_in(nb), .signed_in(sgn), .overflow_in(ovf), .operand_a_out(op_a), .operand_b_out(op_b),
		.wrap_count_out(wraps));

	task automatic end_of_test();
		$display("mismatches %0d comparisons %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_in);
		penable <= 1'b1;
		// only the watchdog ends a wait for pready
		do begin
			@(posedge core_clk_in);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// operands change right after an edge
	task automatic ops(input logic [18:0] t);
		sgn <= t[18];
		na <= t[17:9];
		nb <= t[8:0];
	endtask : ops

	function automatic logic [51:0] prod(input logic [18:0] t);
		logic [51:0] x, y;
		x = t[18] ? {{43{t[17]}}, t[17:9]} : {43'h0, t[17:9]};
		y = t[18] ? {{43{t[8]}}, t[8:0]} : {43'h0, t[8:0]};
		return x * y;
	endfunction : prod

	initial begin
		repeat (20000) @(posedge core_clk_in);
		n_errors++;
		end_of_test();
	end

	initial begin
		repeat (4) @(posedge core_clk_in);
		reset_in <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			check("reset value or unmapped read", 64'(q), 64'h0);
			check("slave error", 64'(e), 64'(i == 6));
		end
		// stage enables and latency in product mode
		for (int c = 0; c < 8; c++) begin
			lat = c % 2 + (c / 2) % 2 + c / 4;
			apb(1'b1, mau_pkg::MAU_CTRL_OFS, 32'(c));
			@(posedge core_clk_in) ops(tab[c % 5]);
			repeat (4) @(posedge core_clk_in);
			@(posedge core_clk_in) ops(tab[c % 5 + 1]);
			for (int k = 0; k <= lat; k++) begin
				if (k > 0) @(posedge core_clk_in);
				#1 check("product latency", 64'(result), 64'(prod(tab[c % 5 + (k == lat)])));
			end
		end
		// enable and reset source selection
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, mau_pkg::MAU_CE_SEL_OFS, 32'({3{2'(s)}}));
			apb(1'b1, mau_pkg::MAU_RST_SEL_OFS, 32'({3{2'(s)}}));
			apb(1'b0, mau_pkg::MAU_RST_SEL_OFS, 32'h0);
			check("reset select", 64'(q), 64'({3{2'(s)}}));
			@(posedge core_clk_in) ops(tab[s]);
			repeat (5) @(posedge core_clk_in);
			@(posedge core_clk_in) ce <= ~(4'h1 << s);
			rst <= ~(4'h1 << s);
			ops(tab[s + 1]);
			repeat (5) @(posedge core_clk_in);
			#1 check("held by enable", 64'(result), 64'(prod(tab[s])));
			@(posedge core_clk_in) ce <= 4'hF;
			rst <= 4'h0;
			repeat (3) @(posedge core_clk_in);
			#1 check("enabled update", 64'(result), 64'(prod(tab[s + 1])));
			@(posedge core_clk_in) rst <= 4'h1 << s;
			@(posedge core_clk_in) rst <= 4'h0;
			#1 check("selected reset", 64'(result), 64'h0);
		end
		apb(1'b1, mau_pkg::MAU_CE_SEL_OFS, 32'h0);
		apb(1'b1, mau_pkg::MAU_RST_SEL_OFS, 32'h0);
		// serial load, msb first
		apb(1'b1, mau_pkg::MAU_CTRL_OFS, 32'h1);
		@(posedge core_clk_in) ops(19'h0);
		for (int i = 17; i >= 0; i--) begin
			@(posedge core_clk_in) load_ser <= 1'b1;
			ser_a <= sa[i];
			ser_b <= sb[i];
		end
		@(posedge core_clk_in) load_ser <= 1'b0;
		#1 check("serial product", 64'(result), 64'({34'h0, sa} * {34'h0, sb}));
		// accumulate with wraps, mode or operands changing every cycle
		apb(1'b1, mau_pkg::MAU_CTRL_OFS, 32'h8);
		@(posedge core_clk_in) rst <= 4'h1;
		@(posedge core_clk_in) rst <= 4'h0;
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk_in) ops(i < 7 ? mt[i % 7][18:0] : 19'h0);
			sub <= i < 7 ? mt[i % 7][19] : 1'b0;
			#1 if (i > 0) check("overflow and sum", 64'({ovf, result}), 64'(mx[i - 1]));
		end
		check("pulses counted", 64'(wraps), 64'h2);
		apb(1'b0, mau_pkg::MAU_RESULT_OFS, 32'h0);
		check("result word", 64'(q), 64'h405);
		check("masked interrupt", 64'(irq), 64'h0);
		apb(1'b1, mau_pkg::MAU_MASK_OFS, 32'h1);
		repeat (2) @(posedge core_clk_in);
		#1 check("unmasked interrupt", 64'(irq), 64'h1);
		apb(1'b0, mau_pkg::MAU_STATUS_OFS, 32'h0);
		check("sticky status", 64'(q), 64'h1);
		repeat (2) @(posedge core_clk_in);
		#1 check("interrupt after clear", 64'(irq), 64'h0);
		apb(1'b0, mau_pkg::MAU_STATUS_OFS, 32'h0);
		check("status cleared", 64'(q), 64'h0);
		end_of_test();
	end
endmodule : tb
